// File: hdl/serial_port_pkg.sv
package serial_port_pkg;
    // Frame geometry
    localparam int INSTR_BITS = 16;          // Instruction word length
    localparam int BYTE_BITS  = 8;           // Data byte length
    localparam int ADDR_W     = 13;          // Start address width
    // Instruction word field positions
    localparam int RW_POS     = 15;          // Read/write select bit
    localparam int CNT_HI     = 14;          // Byte count field, upper bit
    localparam int CNT_LO     = 13;          // Byte count field, lower bit
    localparam int ADDR_HI    = 12;          // Start address, upper bit
    // Byte count codes
    localparam logic [1:0] CNT_ONE    = 2'h0; // One byte
    localparam logic [1:0] CNT_TWO    = 2'h1; // Two bytes
    localparam logic [1:0] CNT_THREE  = 2'h2; // Three bytes
    localparam logic [1:0] CNT_STREAM = 2'h3; // Until chip select rises
    // Reset values
    localparam logic [3:0]  BIT_CNT_RST = 4'h0;    // Bit counter
    localparam logic [15:0] INSTR_RST   = 16'h0000; // Instruction shifter
    localparam logic [7:0]  BYTE_RST    = 8'h00;   // Byte shifters
    localparam logic        PIN_IDLE    = 1'b1;    // Synchroniser preset
    // Last bit index of the instruction and data phases
    localparam logic [3:0] INSTR_LAST = 4'(INSTR_BITS - 1);
    localparam logic [3:0] BYTE_LAST  = 4'(BYTE_BITS - 1);

    // Frame phases
    typedef enum logic [1:0] {
        ST_INSTR = 2'b00,                    // Collecting instruction
        ST_DATA  = 2'b01,                    // Moving data bytes
        ST_DONE  = 2'b10                     // Count reached, wait for CS
    } phase_e;
endpackage : serial_port_pkg

// File: hdl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 3                      // Number of pins
) (
    // Clock and reset
    input  wire logic         I_CLK,
    input  wire logic         I_RST,
    // Pins in, synchronised levels out
    input  wire logic [W-1:0] I_PIN,
    output logic      [W-1:0] O_LVL
);
    import serial_port_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;                    // First stage, read only by s2
        logic [W-1:0] s2;                    // Second stage, safe to use
    } sync_s;

    sync_s state_reg;                        // Registered state
    sync_s state_next;                       // Next state

    // Shift pins through two stages
    always_comb begin
        state_next    = state_reg;
        state_next.s1 = I_PIN;
        state_next.s2 = state_reg.s1;
    end

    // Register stages, idle level at reset
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            state_reg <= {(2 * W){PIN_IDLE}};
        end else begin
            state_reg <= state_next;
        end
    end

    assign O_LVL = state_reg.s2;
endmodule : pin_sync

// File: hdl/serial_port.sv
`timescale 1ns/1ps
module serial_port (
    // Clock and reset
    input  wire logic                           I_CLK,
    input  wire logic                           I_RST,
    // Serial pins
    input  wire logic                           I_SCLK,
    input  wire logic                           I_CS_N,
    input  wire logic                           I_SDIO,
    output logic                                O_SDIO,
    output logic                                O_SDIO_OE,
    // Port configuration
    input  wire logic                           I_LSB_FIRST,
    // Register file access
    output logic                                O_WR_EN,
    output logic                                O_RD_EN,
    output logic [serial_port_pkg::ADDR_W-1:0]  O_ADDR,
    output logic [serial_port_pkg::BYTE_BITS-1:0] O_WR_DATA,
    input  wire logic [serial_port_pkg::BYTE_BITS-1:0] I_RD_DATA
);
    import serial_port_pkg::*;

    // Whole port state
    typedef struct packed {
        phase_e                 phase;       // Frame phase
        logic [3:0]             bit_cnt;     // Bits in current unit
        logic [INSTR_BITS-1:0]  instr;       // Instruction shifter
        logic                   rd;          // Frame is a read
        logic [1:0]             cnt;         // Byte count code
        logic [1:0]             left;        // Bytes still to move, less one
        logic [ADDR_W-1:0]      addr;        // Current byte address
        logic [BYTE_BITS-1:0]   rx;          // Incoming byte
        logic [BYTE_BITS-1:0]   tx;          // Outgoing byte
        logic                   sclk_d;      // Clock level last cycle
        logic                   load;        // Read data arrives now
        logic                   sdo;         // Data line output bit
        logic                   sent;        // Read bit awaits a rise
        logic                   oe;          // Data line enable
        logic                   wr_en;       // Write strobe
        logic                   rd_en;       // Read request strobe
        logic [ADDR_W-1:0]      req_addr;    // Address of strobe
        logic [BYTE_BITS-1:0]   wr_data;     // Byte written
    } port_s;

    port_s state_reg;                        // Registered state
    port_s state_next;                       // Next state

    logic [2:0] lvl;                         // Synchronised pins
    logic       sclk_s;                      // Serial clock level
    logic       cs_n_s;                      // Chip select level
    logic       sdi_s;                       // Data line level
    logic       rise;                        // Serial clock rising
    logic       fall;                        // Serial clock falling

    // Step the byte address in the bit-order direction
    function automatic logic [ADDR_W-1:0] step_addr(
        input logic [ADDR_W-1:0] a,
        input logic              lsb
    );
        step_addr = lsb ? ADDR_W'(a + 1'b1)
                        : ADDR_W'(a - 1'b1);
    endfunction : step_addr

    // Shift one bit into a byte in the bit-order direction
    function automatic logic [BYTE_BITS-1:0] shift_byte(
        input logic [BYTE_BITS-1:0] b,
        input logic                 bit_in,
        input logic                 lsb
    );
        shift_byte = lsb ? {bit_in, b[BYTE_BITS-1:1]}
                         : {b[BYTE_BITS-2:0], bit_in};
    endfunction : shift_byte

    // Pins come from the host's domain
    pin_sync #(
        .W (3)
    ) u_sync (
        .I_CLK (I_CLK),
        .I_RST (I_RST),
        .I_PIN ({I_SCLK, I_CS_N, I_SDIO}),
        .O_LVL (lvl)
    );

    assign sclk_s = lvl[2];
    assign cs_n_s = lvl[1];
    assign sdi_s  = lvl[0];

    // Edges only count while selected
    assign rise = ~cs_n_s & sclk_s & ~state_reg.sclk_d;
    assign fall = ~cs_n_s & ~sclk_s & state_reg.sclk_d;

    // Next-state logic
    always_comb begin
        state_next        = state_reg;
        state_next.sclk_d = sclk_s;
        state_next.wr_en  = 1'b0;
        state_next.rd_en  = 1'b0;
        state_next.load   = state_reg.rd_en;

        // Read data answers one cycle after the request
        if (state_reg.load) begin
            state_next.tx = I_RD_DATA;
        end

        if (cs_n_s) begin
            // Deselected: line released always
            state_next.oe = 1'b0;
            if (state_reg.bit_cnt != BIT_CNT_RST &&
                !(state_reg.phase == ST_INSTR &&
                  state_reg.bit_cnt == 4'(BYTE_BITS))) begin
                // Mid-byte rise resets the port; the instruction's
                // middle byte boundary stalls like a non-streaming data byte boundary
                state_next.phase   = ST_INSTR;
                state_next.bit_cnt = BIT_CNT_RST;
                state_next.instr   = INSTR_RST;
            end else if (state_reg.phase == ST_DONE ||
                         state_reg.cnt == CNT_STREAM &&
                         state_reg.phase == ST_DATA) begin
                // Frame ends, streaming stops here
                state_next.phase = ST_INSTR;
                state_next.instr = INSTR_RST;
            end
            // Otherwise stalled at a boundary, resume later
        end else if (rise) begin
            // Bit on the line is taken by the host now
            state_next.sent = 1'b0;
            case (state_reg.phase)
                ST_INSTR: begin
                    // Instruction bits on first sixteen rises
                    state_next.instr = I_LSB_FIRST
                        ? {sdi_s, state_reg.instr[INSTR_BITS-1:1]}
                        : {state_reg.instr[INSTR_BITS-2:0], sdi_s};
                    state_next.bit_cnt = 4'(state_reg.bit_cnt + 1'b1);
                    if (state_reg.bit_cnt == INSTR_LAST) begin
                        // Decode the finished word
                        state_next.bit_cnt = BIT_CNT_RST;
                        state_next.phase   = ST_DATA;
                        state_next.rd      =
                            state_next.instr[RW_POS];
                        state_next.cnt     =
                            state_next.instr[CNT_HI:CNT_LO];
                        state_next.left    =
                            state_next.instr[CNT_HI:CNT_LO];
                        state_next.addr    =
                            state_next.instr[ADDR_HI:0];
                        if (state_next.instr[RW_POS]) begin
                            // Fetch first read byte
                            state_next.rd_en    = 1'b1;
                            state_next.req_addr =
                                state_next.instr[ADDR_HI:0];
                        end
                    end
                end
                ST_DATA: begin
                    // Data bits captured on rising edges
                    state_next.rx = shift_byte(state_reg.rx, sdi_s,
                                               I_LSB_FIRST);
                    state_next.bit_cnt = 4'(state_reg.bit_cnt + 1'b1);
                    if (state_reg.bit_cnt == BYTE_LAST) begin
                        // Byte complete
                        state_next.bit_cnt = BIT_CNT_RST;
                        state_next.addr    =
                            step_addr(state_reg.addr, I_LSB_FIRST);
                        if (!state_reg.rd) begin
                            // Hand the byte to the register file
                            state_next.wr_en    = 1'b1;
                            state_next.req_addr = state_reg.addr;
                            state_next.wr_data  = state_next.rx;
                        end
                        if (state_reg.cnt != CNT_STREAM &&
                            state_reg.left == CNT_ONE) begin
                            // Last byte: release line, wait for CS
                            state_next.phase = ST_DONE;
                            state_next.oe    = 1'b0;
                        end else begin
                            // More bytes follow
                            if (state_reg.cnt != CNT_STREAM) begin
                                state_next.left =
                                    2'(state_reg.left - 1'b1);
                            end
                            if (state_reg.rd) begin
                                // Prefetch next read byte
                                state_next.rd_en    = 1'b1;
                                state_next.req_addr = state_next.addr;
                            end
                        end
                    end
                end
                ST_DONE: begin
                    // Extra clocks after the count are ignored
                    state_next.phase = ST_DONE;
                end
                default: begin
                    // Unknown phase recovers to idle
                    state_next.phase   = ST_INSTR;
                    state_next.bit_cnt = BIT_CNT_RST;
                end
            endcase
        end else if (fall && state_reg.phase == ST_DATA &&
                     state_reg.rd) begin
            // Read bits launched on falling edges
            state_next.oe  = 1'b1;
            state_next.sent = 1'b1;
            state_next.sdo = I_LSB_FIRST ? state_reg.tx[0]
                                         : state_reg.tx[BYTE_BITS-1];
            state_next.tx  = I_LSB_FIRST
                ? {1'b0, state_reg.tx[BYTE_BITS-1:1]}
                : {state_reg.tx[BYTE_BITS-2:0], 1'b0};
        end else if (state_reg.phase == ST_DATA && state_reg.rd &&
                     state_reg.sent) begin
            // Resumed after a stall: waiting bit goes back on the line
            state_next.oe = 1'b1;
        end
    end

    // State register
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            state_reg          <= '0;
            state_reg.phase    <= ST_INSTR;
            state_reg.bit_cnt  <= BIT_CNT_RST;
            state_reg.instr    <= INSTR_RST;
            state_reg.rx       <= BYTE_RST;
            state_reg.tx       <= BYTE_RST;
            state_reg.wr_data  <= BYTE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from registers
    assign O_SDIO    = state_reg.sdo;
    assign O_SDIO_OE = state_reg.oe;
    assign O_WR_EN   = state_reg.wr_en;
    assign O_RD_EN   = state_reg.rd_en;
    assign O_ADDR    = state_reg.req_addr;
    assign O_WR_DATA = state_reg.wr_data;
endmodule : serial_port

// File: bench/serial_port_sva.sv
`timescale 1ns/1ps
module serial_port_sva (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST,
    // Pins and strobes watched
    input wire logic I_SCLK,
    input wire logic I_CS_N,
    input wire logic O_SDIO,
    input wire logic O_SDIO_OE,
    input wire logic O_WR_EN,
    input wire logic O_RD_EN
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);
    // Deselected port leaves the line alone
    property p_float;
        I_CS_N [*5] |-> !O_SDIO_OE;
    endproperty
    a_float: assert property (p_float)
        else $error("line driven while deselected");
    property p_quiet;
        I_CS_N [*5] |-> !(O_WR_EN || O_RD_EN);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("strobe while deselected");
    property p_wr_pulse;
        O_WR_EN |=> !O_WR_EN;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse)
        else $error("write strobe longer than one cycle");
    property p_rd_pulse;
        O_RD_EN |=> !O_RD_EN;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("read strobe longer than one cycle");
    property p_one;
        !(O_WR_EN && O_RD_EN);
    endproperty
    a_one: assert property (p_one)
        else $error("read and write strobes together");
    // Writes never see the port driving
    property p_wr_float;
        O_WR_EN |-> !O_SDIO_OE;
    endproperty
    a_wr_float: assert property (p_wr_float)
        else $error("line driven during write");
    // Read bits move only after a falling clock
    property p_launch;
        $past(O_SDIO_OE) && O_SDIO_OE && $changed(O_SDIO)
            |-> !$past(I_SCLK, 2);
    endproperty
    a_launch: assert property (p_launch)
        else $error("read bit changed outside low clock");
    property p_oe_rise;
        $rose(O_SDIO_OE) |-> !I_SCLK && !I_CS_N;
    endproperty
    a_oe_rise: assert property (p_oe_rise)
        else $error("drive began outside a falling clock");
endmodule : serial_port_sva

// File: bench/ctrl_host.sv
`timescale 1ns/1ps
module ctrl_host (
    // Link pins driven by the host
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_d,
    // Resolved data line and bit order
    input  wire logic i_q,
    input  wire logic i_lsb
);
    // Idle: deselected, clock parked low
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_d    = 1'b0;
    end
    // One clock: line set while low, taken on rise
    task automatic tick(input logic b, input logic drv, output logic q);
        o_d = drv ? b : ~o_d;              // Released: toggles
        #62.5 o_sclk = 1'b1;
        q = i_q;
        #62.5 o_sclk = 1'b0;
    endtask : tick
    // Clocks while deselected
    task automatic stray(input int n);
        logic q;
        repeat (n) tick(1'b1, 1'b1, q);
    endtask : stray
    // Whole frame; select lifted before bit number stall
    task automatic frame(input logic [15:0] ins, input logic [31:0] wd,
                         input int nbits, input int stall,
                         output logic [31:0] rd);
        logic q;
        int   k;
        int   x;
        rd = '0;
        #100 o_cs_n = 1'b0;
        for (k = 0; k < nbits; k++) begin
            x = 8 * ((k - 16) / 8) + (i_lsb ? k % 8 : 7 - k % 8);
            if (k == stall) begin
                #100 o_cs_n = 1'b1;
                #300 o_cs_n = 1'b0;
            end
            if (k < 16)
                tick(ins[i_lsb ? k : 15 - k], 1'b1, q);
            else begin
                tick(wd[x], !ins[15], q);
                rd[x] = q;
            end
        end
        #100 o_cs_n = 1'b1;
        #200;
    endtask : frame
endmodule : ctrl_host

// File: bench/serial_port_tb.sv
`timescale 1ns/1ps
module serial_port_tb;
    import serial_port_pkg::*;
    typedef struct {
        logic        lsb;  // Bit order
        logic [15:0] ins;  // Instruction word
        logic [31:0] wd;   // Bytes sent, first in low byte
        int          nb;   // Bytes clocked
        int          n;    // Strobes expected
    } row_s;
    row_s rows [6] = '{
        '{1'b0, 16'h0012, 32'h3c, 1, 1},
        '{1'b1, 16'h2020, 32'ha55a, 2, 2},
        '{1'b0, 16'hc005, 32'h0, 3, 3},
        '{1'b1, 16'he0fe, 32'h0, 4, 5},  // Stream prefetches one ahead
        '{1'b0, 16'h6001, 32'h778899, 3, 3},
        '{1'b0, 16'h0030, 32'h1122, 2, 1}
    };
    logic clk, rst, lsb, sclk, cs_n, hd, sdio, o_sdio, oe, wr, rd;
    logic [ADDR_W-1:0]    addr;  // Strobe address
    logic [BYTE_BITS-1:0] wdat;  // Written byte
    logic [20:0]          wq [$]; // Writes seen
    logic [12:0]          rq [$]; // Reads seen
    logic [31:0]          got;   // Bytes read back
    int fail_count, total_checks, cycles;
    // Wire: port drives when enabled, else host
    assign sdio = oe ? o_sdio : hd;
    ctrl_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_d(hd), .i_q(sdio),
                    .i_lsb(lsb));
    serial_port uut (.I_CLK(clk), .I_RST(rst), .I_SCLK(sclk),
        .I_CS_N(cs_n), .I_SDIO(sdio), .O_SDIO(o_sdio), .O_SDIO_OE(oe),
        .I_LSB_FIRST(lsb), .O_WR_EN(wr), .O_RD_EN(rd), .O_ADDR(addr),
        .O_WR_DATA(wdat), .I_RD_DATA(addr[7:0] ^ 8'ha5));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Log every strobe
    always @(posedge clk) begin
        if (wr === 1'b1) wq.push_back({addr, wdat});
        if (rd === 1'b1) rq.push_back(addr);
    end
    task automatic check(string nm, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (e !== g) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic run_row(input row_s r);
        logic [12:0] a;
        lsb <= r.lsb;
        wq.delete();
        rq.delete();
        @(posedge clk);
        host.frame(r.ins, r.wd, 16 + 8 * r.nb, -1, got);
        check("count", r.n, r.ins[15] ? rq.size() : wq.size());
        for (int i = 0; i < r.n; i++) begin
            a = r.ins[12:0] + (r.lsb ? 13'(i) : -13'(i));
            if (r.ins[15]) begin
                check("raddr", 32'(a), 32'(rq[i]));
                if (i < r.nb) begin
                    // Last streaming prefetch is never clocked out
                    check("rdata", 32'(a[7:0] ^ 8'ha5),
                          32'(got[8*i+:8]));
                end
            end else begin
                check("waddr", 32'(a), 32'(wq[i][20:8]));
                check("wdata", 32'(r.wd[8*i+:8]),
                      32'(wq[i][7:0]));
            end
        end
    endtask : run_row
    initial begin
        rst = 1'b1;
        lsb = 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        foreach (rows[i]) begin
            run_row(rows[i]);
            $display("row %0d done", i);
        end
        // Reset in mid-run clears outputs
        @(posedge clk);
        rst <= 1'b1;
        lsb <= 1'b0;
        repeat (2) @(posedge clk);
        check("reset", 0, {o_sdio, oe, wr, rd, addr, wdat});
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        wq.delete();
        rq.delete();
        host.stray(20);
        host.frame(16'h2040, 32'hffff, 20, -1, got);
        check("ignored", 0, wq.size());
        check("ignored_rd", 0, rq.size());
        $display("stray and abort done");
        host.frame(16'h2040, 32'hbeef, 32, 24, got);
        check("stall", 2, wq.size());
        check("stall0", {13'h040, 8'hef}, 32'(wq[0]));
        check("stall1", {13'h03f, 8'hbe}, 32'(wq[1]));
        // Stall after the first instruction byte
        wq.delete();
        host.frame(16'h0050, 32'h5a, 24, 8, got);
        check("stall_ins", {13'h050, 8'h5a}, 32'(wq[0]));
        // Read stalled between its two bytes
        host.frame(16'ha007, 32'h0, 32, 24, got);
        check("stall_rd", 32'h0000a3a2, got);
        $display("stall done");
        close_out();
    end
endmodule : serial_port_tb
bind serial_port serial_port_sva chk (.I_CLK(I_CLK), .I_RST(I_RST),
    .I_SCLK(I_SCLK), .I_CS_N(I_CS_N), .O_SDIO(O_SDIO),
    .O_SDIO_OE(O_SDIO_OE), .O_WR_EN(O_WR_EN), .O_RD_EN(O_RD_EN));
